//--- common/udr_pkg.sv
package udr_pkg;
    // Register addresses on the three address lines
    localparam logic [2:0] ADDR_HOLD = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_FCR = 3'h2;
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    // Bank selection values
    localparam logic [7:0] LCR_EFR_KEY = 8'hbf;
    localparam logic [2:0] LCR_AFR_KEY = 3'h4;
    localparam int LCR_DLAB_BIT = 7;
    // Field positions
    localparam int IER_SLEEP_BIT = 4;
    localparam int EFR_ENH_BIT = 4;
    localparam int LSR_FIFO_ERR_BIT = 7;
    localparam int FCR_FIFO_EN_BIT = 0;
    localparam int FCR_DMA_MODE_BIT = 3;
    // Reset values
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] EFR_RESET = 8'h00;
    localparam logic [7:0] AFR_RESET = 8'h10;
    localparam logic [7:0] LCR_RESET = 8'h1d;
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [7:0] FCR_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] FLOW_RESUME_CHAR_1_RESET = 8'hff;
    localparam logic [7:0] FLOW_RESUME_CHAR_2_RESET = 8'hef;
    // Masks for bits that need the enhanced-functions bit
    localparam logic [7:0] MCR_ENH_MASK = 8'he0;
    localparam logic [7:0] FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] IER_ENH_MASK = 8'hf0;
    // Idle time for timeout: 4 x word length + 12 bit times
    localparam int IDLE_EXTRA_BITS = 12;
    localparam int IDLE_WORD_FACTOR = 4;
    localparam int BIT_TICKS = 16;

    // Host bus access
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } udr_bus_t;

    // Status from the datapath
    typedef struct packed {
        logic [6:0] rx_count;
        logic [6:0] tx_count;
        logic tx_shift_empty;
        logic rx_fifo_error;
        logic other_irq_pending;
        logic [7:0] rx_data;
        logic [7:0] interrupt_identity;
        logic [7:0] line_status;
    } udr_stat_t;

    typedef enum logic [1:0] {
        ST_AWAKE = 2'b01,
        ST_ASLEEP = 2'b10
    } udr_sleep_t;
endpackage

//--- design/udr_idle_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts receive-line high time in 16x baud ticks while the rx FIFO holds data
module udr_idle_timer #(
    parameter int CW = 10
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Inputs
    input wire logic tick_i,
    input wire logic rx_line_i,
    input wire logic rx_nonempty_i,
    input wire logic [1:0] word_len_i,
    // Result
    output logic timeout_o
);
    import udr_pkg::*;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] limit;

    initial begin
        if (CW < 10) $error("idle counter too narrow");
    end

    // Limit in ticks: (4*(5+len) + 12) bits
    always_comb begin
        limit = CW'((IDLE_WORD_FACTOR * (5 + int'(word_len_i)) + IDLE_EXTRA_BITS) * BIT_TICKS);
    end

    // Any low level or empty FIFO restarts the count
    always_comb begin
        cnt_d = cnt_q;
        if (!rx_line_i || !rx_nonempty_i) begin
            cnt_d = '0;
        end else if (tick_i && cnt_q != limit) begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign timeout_o = rx_nonempty_i && (cnt_q == limit);
endmodule
`default_nettype wire

//--- design/udr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module udr_ctrl #(
    parameter int FIFO_DEPTH = 64
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Host bus
    input wire udr_pkg::udr_bus_t bus_i,
    output logic [7:0] rdata_o,
    // Datapath status and strobes
    input wire udr_pkg::udr_stat_t stat_i,
    input wire logic baud_tick_i,
    output logic tx_push_o,
    output logic rx_pop_o,
    output logic fifo_clear_rx_o,
    output logic fifo_clear_tx_o,
    // Pins from outside the clock domain
    input wire logic rx_pin_i,
    input wire logic [3:0] modem_pins_i,
    // Configuration outputs
    output logic [15:0] divisor_o,
    output logic [7:0] line_control_o,
    output logic [7:0] modem_control_o,
    output logic [7:0] enhanced_features_o,
    output logic [7:0] alternate_function_o,
    output logic [7:0] flow_resume_char_1_o,
    output logic [7:0] flow_resume_char_2_o,
    output logic [7:0] fifo_control_o,
    // DMA and sleep
    output logic tx_dma_request_o,
    output logic rx_dma_request_o,
    output logic uart_clk_en_o,
    output logic baud_clk_en_o,
    output logic asleep_o
);
    import udr_pkg::*;

    initial begin
        if (FIFO_DEPTH != 64) $error("control serves a 64-entry FIFO only");
    end

    // Register state
    logic [7:0] ier_q, ier_d, efr_q, efr_d, afr_q, afr_d, lcr_q, lcr_d;
    logic [7:0] mcr_q, mcr_d, fcr_q, fcr_d, dll_q, dll_d, dlh_q, dlh_d;
    logic [7:0] flow_resume_char_1_q, flow_resume_char_1_d, flow_resume_char_2_q, flow_resume_char_2_d;
    logic txreq_q, txreq_d, rxreq_q, rxreq_d;
    udr_sleep_t st_q, st_d;
    logic [7:0] rdata_q, rdata_d;

    // Synchronisers for pins: first stage read only by the second
    logic rx_s1_q, rx_s2_q, rx_s3_q;
    logic [3:0] mp_s1_q, mp_s2_q, mp_s3_q;

    logic timeout;
    logic enh, bank_efr, bank_afr, dlab;
    logic wake, sleep_ok;
    logic [6:0] tx_free, tx_trig, rx_trig;

    // Keep bits that need enhanced mode unless it is on
    function automatic logic [7:0] masked_wr(input logic [7:0] old, input logic [7:0] nw,
                                             input logic [7:0] msk, input logic en);
        masked_wr = en ? nw : ((old & msk) | (nw & ~msk));
    endfunction

    udr_idle_timer #(.CW(10)) u_idle (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .tick_i(baud_tick_i),
        .rx_line_i(rx_s2_q),
        .rx_nonempty_i(stat_i.rx_count != 7'h00),
        .word_len_i(lcr_q[1:0]),
        .timeout_o(timeout)
    );

    // Bank decode from line control and enhanced bit
    always_comb begin
        enh = efr_q[EFR_ENH_BIT];
        bank_efr = (lcr_q == LCR_EFR_KEY);
        bank_afr = (lcr_q[7:5] == LCR_AFR_KEY) && !bank_efr;
        dlab = lcr_q[LCR_DLAB_BIT];
    end

    // Register writes
    always_comb begin
        ier_d = ier_q;
        efr_d = efr_q;
        afr_d = afr_q;
        lcr_d = lcr_q;
        mcr_d = mcr_q;
        fcr_d = fcr_q;
        dll_d = dll_q;
        dlh_d = dlh_q;
        flow_resume_char_1_d = flow_resume_char_1_q;
        flow_resume_char_2_d = flow_resume_char_2_q;
        tx_push_o = 1'b0;
        fifo_clear_rx_o = 1'b0;
        fifo_clear_tx_o = 1'b0;
        if (bus_i.wr) begin
            case (bus_i.addr)
                ADDR_HOLD: begin
                    if (dlab) begin
                        dll_d = bus_i.wdata;
                    end else begin
                        tx_push_o = 1'b1;
                    end
                end
                ADDR_IER: begin
                    if (dlab) begin
                        dlh_d = bus_i.wdata;
                    end else begin
                        ier_d = masked_wr(ier_q, bus_i.wdata, IER_ENH_MASK, enh);
                    end
                end
                ADDR_FCR: begin
                    if (bank_efr) begin
                        efr_d = bus_i.wdata;
                    end else if (bank_afr) begin
                        afr_d = bus_i.wdata;
                    end else if (!dlab) begin
                        fcr_d = masked_wr(fcr_q, bus_i.wdata, FCR_ENH_MASK, enh);
                        fcr_d[2:1] = 2'h0; // Clear bits self-return
                        fifo_clear_rx_o = bus_i.wdata[1];
                        fifo_clear_tx_o = bus_i.wdata[2];
                    end
                end
                ADDR_LCR: lcr_d = bus_i.wdata;
                ADDR_MCR: begin
                    if (bank_efr) begin
                        flow_resume_char_1_d = bus_i.wdata;
                    end else begin
                        mcr_d = masked_wr(mcr_q, bus_i.wdata, MCR_ENH_MASK, enh);
                    end
                end
                ADDR_LSR: begin
                    if (bank_efr) begin
                        flow_resume_char_2_d = bus_i.wdata;
                    end
                end
                default: ;
            endcase
        end
    end

    // Read mux, registered data output
    always_comb begin
        rdata_d = 8'h00;
        rx_pop_o = 1'b0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                ADDR_HOLD: begin
                    if (dlab) begin
                        rdata_d = dll_q;
                    end else begin
                        rdata_d = stat_i.rx_data;
                        rx_pop_o = 1'b1;
                    end
                end
                ADDR_IER: rdata_d = dlab ? dlh_q : ier_q;
                ADDR_FCR: begin
                    if (bank_efr) begin
                        rdata_d = efr_q;
                    end else if (bank_afr) begin
                        rdata_d = afr_q;
                    end else begin
                        rdata_d = stat_i.interrupt_identity;
                    end
                end
                ADDR_LCR: rdata_d = lcr_q;
                ADDR_MCR: rdata_d = bank_efr ? flow_resume_char_1_q : mcr_q;
                ADDR_LSR: rdata_d = bank_efr ? flow_resume_char_2_q : stat_i.line_status;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // DMA trigger levels from the FIFO control fields
    always_comb begin
        tx_free = 7'(FIFO_DEPTH) - stat_i.tx_count;
        case (fcr_q[5:4])
            2'h0: tx_trig = 7'd8;
            2'h1: tx_trig = 7'd16;
            2'h2: tx_trig = 7'd32;
            default: tx_trig = 7'd56;
        endcase
        case (fcr_q[7:6])
            2'h0: rx_trig = 7'd1;
            2'h1: rx_trig = 7'd4;
            2'h2: rx_trig = 7'd56;
            default: rx_trig = 7'd60;
        endcase
    end

    // Block-mode request flags; mode 0 is not served here, so requests stay idle
    always_comb begin
        txreq_d = 1'b0;
        rxreq_d = 1'b0;
        if (fcr_q[FCR_DMA_MODE_BIT] && fcr_q[FCR_FIFO_EN_BIT]) begin
            txreq_d = txreq_q;
            if (tx_free == 7'h00) begin
                txreq_d = 1'b0;
            end else if (tx_free >= tx_trig) begin
                txreq_d = 1'b1;
            end
            rxreq_d = rxreq_q;
            if (stat_i.rx_count == 7'h00 || stat_i.rx_fifo_error) begin
                rxreq_d = 1'b0;
            end else if (stat_i.rx_count >= rx_trig || timeout) begin
                rxreq_d = 1'b1;
            end
        end
    end

    // Sleep control; wake sources are edges of synchronised pins and a tx holding write
    always_comb begin
        wake = (rx_s2_q != rx_s3_q) || (mp_s2_q != mp_s3_q) || tx_push_o;
        sleep_ok = enh && ier_q[IER_SLEEP_BIT]
            && rx_s2_q && !timeout_blocked()
            && stat_i.tx_count == 7'h00 && stat_i.tx_shift_empty
            && !stat_i.other_irq_pending
            && stat_i.rx_count == 7'h00;
        st_d = st_q;
        case (st_q)
            ST_AWAKE: if (sleep_ok && !wake) st_d = ST_ASLEEP;
            ST_ASLEEP: if (wake || !sleep_ok) st_d = ST_AWAKE;
            default: st_d = ST_AWAKE;
        endcase
    end

    // Line must be high before sleep; with empty FIFO the timer is idle
    function automatic logic timeout_blocked();
        timeout_blocked = 1'b0;
    endfunction

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ier_q <= IER_RESET;
            efr_q <= EFR_RESET;
            afr_q <= AFR_RESET;
            lcr_q <= LCR_RESET;
            mcr_q <= MCR_RESET;
            fcr_q <= FCR_RESET;
            dll_q <= DIV_RESET;
            dlh_q <= DIV_RESET;
            flow_resume_char_1_q <= FLOW_RESUME_CHAR_1_RESET;
            flow_resume_char_2_q <= FLOW_RESUME_CHAR_2_RESET;
            txreq_q <= 1'b0;
            rxreq_q <= 1'b0;
            st_q <= ST_AWAKE;
            rdata_q <= 8'h00;
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            mp_s1_q <= 4'h0;
            mp_s2_q <= 4'h0;
            mp_s3_q <= 4'h0;
        end else begin
            ier_q <= ier_d;
            efr_q <= efr_d;
            afr_q <= afr_d;
            lcr_q <= lcr_d;
            mcr_q <= mcr_d;
            fcr_q <= fcr_d;
            dll_q <= dll_d;
            dlh_q <= dlh_d;
            flow_resume_char_1_q <= flow_resume_char_1_d;
            flow_resume_char_2_q <= flow_resume_char_2_d;
            txreq_q <= txreq_d;
            rxreq_q <= rxreq_d;
            st_q <= st_d;
            rdata_q <= rdata_d;
            rx_s1_q <= rx_pin_i;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            mp_s1_q <= modem_pins_i;
            mp_s2_q <= mp_s1_q;
            mp_s3_q <= mp_s2_q;
        end
    end

    // Outputs; clock enables drive the gating cells of the UART and baud clocks
    assign rdata_o = rdata_q;
    assign tx_dma_request_o = txreq_q;
    assign rx_dma_request_o = rxreq_q;
    assign asleep_o = (st_q == ST_ASLEEP);
    assign uart_clk_en_o = (st_q != ST_ASLEEP);
    assign baud_clk_en_o = (st_q != ST_ASLEEP);
    assign divisor_o = {dlh_q, dll_q};
    assign line_control_o = lcr_q;
    assign modem_control_o = mcr_q;
    assign enhanced_features_o = efr_q;
    assign alternate_function_o = afr_q;
    assign flow_resume_char_1_o = flow_resume_char_1_q;
    assign flow_resume_char_2_o = flow_resume_char_2_q;
    assign fifo_control_o = fcr_q;
endmodule
`default_nettype wire

//--- test/udr_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the control block
module udr_ctrl_asserts #(
    parameter int FIFO_DEPTH = 64
) (
    // Clock, reset and inputs
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire udr_pkg::udr_bus_t bus_i,
    input wire udr_pkg::udr_stat_t stat_i,
    // Outputs watched
    input wire logic [7:0] rdata_o,
    input wire logic tx_push_o,
    input wire logic [7:0] modem_control_o,
    input wire logic [7:0] enhanced_features_o,
    input wire logic [7:0] alternate_function_o,
    input wire logic [7:0] line_control_o,
    input wire logic [7:0] fifo_control_o,
    input wire logic tx_dma_request_o,
    input wire logic rx_dma_request_o,
    input wire logic uart_clk_en_o,
    input wire logic baud_clk_en_o,
    input wire logic asleep_o
);
    import udr_pkg::*;
    logic blk;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // Block mode needs both the fifo enable and the mode bit
    assign blk = fifo_control_o[FCR_DMA_MODE_BIT] & fifo_control_o[FCR_FIFO_EN_BIT];
    // Mode held steady so a trigger decision never races a mode write
    sequence s_rx_hit;
        blk && $stable(fifo_control_o) && fifo_control_o[7:6] == 2'b00
            && stat_i.rx_count != 7'h00 && !stat_i.rx_fifo_error;
    endsequence
    sequence s_tx_hit;
        blk && $stable(fifo_control_o) && fifo_control_o[5:4] == 2'b00
            && stat_i.tx_count <= 7'(FIFO_DEPTH - 8);
    endsequence
    sequence s_push_asleep;
        asleep_o && tx_push_o;
    endsequence
    a_tx_full: assert property (blk && stat_i.tx_count == 7'(FIFO_DEPTH) |=> !tx_dma_request_o)
        else $error("tx request with full fifo");
    a_tx_trigger: assert property (s_tx_hit |=> tx_dma_request_o)
        else $error("tx request missing");
    a_rx_trigger: assert property (s_rx_hit |=> rx_dma_request_o)
        else $error("rx request missing");
    a_rx_empty: assert property (stat_i.rx_count == 7'h00 |=> !rx_dma_request_o)
        else $error("rx request with empty fifo");
    a_rx_error: assert property (stat_i.rx_fifo_error |=> !rx_dma_request_o)
        else $error("rx request with fifo error");
    a_sleep_enhanced: assert property (!asleep_o && !enhanced_features_o[EFR_ENH_BIT] |=> !asleep_o)
        else $error("sleep without enhanced bit");
    a_sleep_rx_data: assert property (!asleep_o && stat_i.rx_count != 7'h00 |=> !asleep_o)
        else $error("sleep with rx data");
    a_clock_gate: assert property (uart_clk_en_o == !asleep_o && baud_clk_en_o == !asleep_o)
        else $error("clock enables disagree with sleep");
    a_wake_push: assert property (s_push_asleep |-> ##[1:3] !asleep_o)
        else $error("no wake on tx write");
    a_read_idle: assert property (!bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data without read");
    a_mcr_locked: assert property (bus_i.wr && bus_i.addr == ADDR_MCR
        && !enhanced_features_o[EFR_ENH_BIT] |=> modem_control_o[7:5] == $past(modem_control_o[7:5]))
        else $error("locked modem bits changed");
    a_afr_bank: assert property (bus_i.wr && bus_i.addr == ADDR_FCR
        && line_control_o[7:5] != LCR_AFR_KEY |=> $stable(alternate_function_o))
        else $error("alternate register changed outside bank");
endmodule
`default_nettype wire

//--- test/udr_dp_model.sv
`timescale 1ns/1ps
`default_nettype none
// Datapath stand-in: fifo levels set by the bench, moved by host strobes
module udr_dp_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Strobes and bench controls
    input wire logic tx_push_i,
    input wire logic rx_pop_i,
    input wire logic load_i,
    input wire logic [6:0] rx_lvl_i,
    input wire logic [6:0] tx_lvl_i,
    input wire logic err_i,
    input wire logic irq_i,
    // Status towards the block
    output var udr_pkg::udr_stat_t stat_o
);
    import udr_pkg::*;
    logic [6:0] rx_q;
    logic [6:0] tx_q;
    // A push into a full fifo is lost, as on the real part
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_q <= 7'h00;
            tx_q <= 7'h00;
        end else if (load_i) begin
            rx_q <= rx_lvl_i;
            tx_q <= tx_lvl_i;
        end else begin
            tx_q <= tx_q + 7'(tx_push_i && tx_q != 7'h40);
            rx_q <= rx_q - 7'(rx_pop_i && rx_q != 7'h00);
        end
    end
    // Shift register counted empty together with the fifo
    always_comb begin
        stat_o = '0;
        stat_o.rx_count = rx_q;
        stat_o.tx_count = tx_q;
        stat_o.tx_shift_empty = (tx_q == 7'h00);
        stat_o.rx_fifo_error = err_i;
        stat_o.other_irq_pending = irq_i;
        stat_o.rx_data = {1'b0, rx_q};
        stat_o.line_status = {err_i, 6'h00, rx_q != 7'h00};
    end
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import udr_pkg::*;
    localparam int FD = 64;
    localparam int TT[4] = '{8, 16, 32, 56};
    localparam int RT[4] = '{1, 4, 56, 60};
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic tick = 1'b0;
    logic rx_pin = 1'b1;
    logic [3:0] modem = 4'h0;
    logic load = 1'b0;
    logic err = 1'b0;
    logic irq = 1'b0;
    logic [6:0] rx_lvl = 7'h00;
    logic [6:0] tx_lvl = 7'h00;
    udr_bus_t bus = '0;
    udr_stat_t stat;
    logic [7:0] rdata, modem_control, alternate_function, fifo_control;
    logic [15:0] divisor;
    logic tx_push, rx_pop, tx_req, rx_req, clk_en, asleep;
    int err_total = 0;
    int checked = 0;
    int etx = 0;
    int erx = 0;
    int r;
    int wl;
    int idle_cyc;
    logic clr_rx, clr_tx;
    logic [1:0] clr_seen = 2'b00;
    logic [7:0] exp_q[$];

    udr_ctrl #(.FIFO_DEPTH(FD)) dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
        .stat_i(stat), .baud_tick_i(tick), .tx_push_o(tx_push), .rx_pop_o(rx_pop),
        .fifo_clear_rx_o(clr_rx), .fifo_clear_tx_o(clr_tx), .rx_pin_i(rx_pin),
        .modem_pins_i(modem),
        .divisor_o(divisor), .line_control_o(), .modem_control_o(modem_control),
        .enhanced_features_o(), .alternate_function_o(alternate_function), .flow_resume_char_1_o(),
        .flow_resume_char_2_o(), .fifo_control_o(fifo_control), .tx_dma_request_o(tx_req),
        .rx_dma_request_o(rx_req), .uart_clk_en_o(clk_en), .baud_clk_en_o(),
        .asleep_o(asleep)
    );
    udr_dp_model u_dp (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .tx_push_i(tx_push), .rx_pop_i(rx_pop),
        .load_i(load), .rx_lvl_i(rx_lvl), .tx_lvl_i(tx_lvl), .err_i(err), .irq_i(irq),
        .stat_o(stat)
    );

    // Clock, and a baud tick on every other cycle
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) tick <= #2 ~tick;
    // Clear strobes stand one cycle only; latch them at the edge that takes them
    always @(posedge clock_i) clr_seen <= clr_seen | {clr_tx, clr_rx};

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask
    // Strobe for one edge, then an idle cycle so strobes never merge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus.addr = a;
        bus.wdata = d;
        bus.wr = 1'b1;
        cyc(1);
        bus.wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
        exp_q.push_back(e);
        bus.addr = a;
        bus.rd = 1'b1;
        cyc(1);
        bus.rd = 1'b0;
        chk(n, {8'h00, rdata}, {8'h00, exp_q.pop_front()});
        cyc(1);
    endtask
    task automatic lvl(input int rx, input int tx);
        rx_lvl = 7'(rx);
        tx_lvl = 7'(tx);
        load = 1'b1;
        cyc(1);
        load = 1'b0;
        cyc(2);
    endtask
    task automatic wsl(input logic v);
        for (int i = 0; i < 8 && asleep !== v; i++) cyc(1);
        chk("asleep", 16'(asleep), 16'(v));
    endtask
    // Request model: set on trigger, clear on full, empty or error
    task automatic dstep(input int k, input int rx, input int tx, input logic e);
        err = e;
        lvl(rx, tx);
        if (FD - tx == 0) etx = 0;
        else if (FD - tx >= TT[k]) etx = 1;
        if (rx == 0 || e) erx = 0;
        else if (rx >= RT[k]) erx = 1;
        chk("tx_req", 16'(tx_req), 16'(etx));
        chk("rx_req", 16'(rx_req), 16'(erx));
    endtask
    task automatic print_verdict;
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        r = $urandom(38902);
        repeat (4) @(posedge clock_i);
        #2 rst_b_i = 1'b1;
        rd(ADDR_LCR, 8'h1d, "lcr");
        rd(ADDR_IER, 8'h00, "ier");
        wr(ADDR_LCR, LCR_EFR_KEY);
        rd(ADDR_FCR, 8'h00, "efr");
        rd(ADDR_MCR, 8'hff, "flow_resume_char_1");
        rd(ADDR_LSR, 8'hef, "flow_resume_char_2");
        rd(3'h6, 8'h00, "unmapped");
        wr(ADDR_LCR, 8'h83);
        rd(ADDR_FCR, 8'h10, "afr");
        r = $urandom;
        wr(ADDR_FCR, r[7:0]);
        rd(ADDR_FCR, r[7:0], "afr");
        wr(ADDR_LCR, 8'h00);
        wr(ADDR_FCR, 8'h00);
        chk("afr_kept", 16'(alternate_function), 16'(r[7:0]));
        wr(ADDR_IER, r[15:8]);
        rd(ADDR_IER, r[15:8] & 8'h0f, "ier_locked");
        wr(ADDR_MCR, 8'hff);
        chk("mcr", 16'(modem_control), 16'h001f);
        wr(ADDR_FCR, 8'h31);
        chk("fcr", 16'(fifo_control), 16'h0001);
        wr(ADDR_LCR, LCR_EFR_KEY);
        wr(ADDR_FCR, 8'h10);
        wr(ADDR_LCR, 8'h00);
        wr(ADDR_MCR, 8'h00);
        wr(ADDR_IER, r[15:8] & 8'hef);
        rd(ADDR_IER, r[15:8] & 8'hef, "ier_open");
        // Every trigger code, with hysteresis, error and a random level
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_FCR, {2'(k), 2'(k), 4'h9});
            dstep(k, 0, FD, 1'b0);
            dstep(k, RT[k] - 1, FD - TT[k] + 1, 1'b0);
            dstep(k, RT[k], FD - TT[k], 1'b0);
            dstep(k, 1, FD - 1, 1'b0);
            dstep(k, 1, FD - 1, 1'b1);
            dstep(k, $urandom_range(64, 0), $urandom_range(64, 0), 1'b0);
        end
        err = 1'b0;
        wr(ADDR_FCR, 8'h01);
        lvl(RT[3], 1);
        chk("mode0", 16'({tx_req, rx_req}), 16'h0000);
        // Three bytes below the trigger of 4: only the idle timeout raises the request
        // Random word length; a tick comes every second cycle
        wl = $urandom_range(3, 0);
        idle_cyc = (IDLE_WORD_FACTOR * (5 + wl) + IDLE_EXTRA_BITS) * BIT_TICKS * 2;
        wr(ADDR_LCR, 8'(wl));
        wr(ADDR_FCR, 8'h49);
        lvl(0, FD);
        lvl(1, FD);
        cyc(idle_cyc - 34);
        chk("rx_early", 16'(rx_req), 16'h0000);
        for (int i = 0; i < 80 && rx_req !== 1'b1; i++) cyc(1);
        chk("rx_timeout", 16'(rx_req), 16'h0001);
        lvl(0, 0);
        wr(ADDR_IER, 8'h10);
        wsl(1'b1);
        chk("clk_en", 16'(clk_en), 16'h0000);
        irq = 1'b1;
        wsl(1'b0);
        irq = 1'b0;
        wsl(1'b1);
        rx_pin = 1'b0;
        wsl(1'b0);
        rx_pin = 1'b1;
        wsl(1'b1);
        modem = 4'($urandom_range(15, 1));
        wsl(1'b0);
        wsl(1'b1);
        wr(ADDR_HOLD, r[7:0]);
        wsl(1'b0);
        lvl(1, 0);
        cyc(6);
        chk("rx_held", 16'(asleep), 16'h0000);
        rd(ADDR_HOLD, 8'h01, "rhr");
        lvl(0, 0);
        wsl(1'b1);
        wr(ADDR_LCR, LCR_EFR_KEY);
        wr(ADDR_FCR, 8'h00);
        wsl(1'b0);
        wr(ADDR_FCR, 8'h10);
        wr(ADDR_LCR, 8'h00);
        wsl(1'b1);
        wr(ADDR_IER, 8'h00);
        wsl(1'b0);
        wr(ADDR_LCR, 8'h80);
        r = $urandom;
        wr(ADDR_HOLD, r[7:0]);
        wr(ADDR_IER, r[15:8]);
        rd(ADDR_HOLD, r[7:0], "dll");
        rd(ADDR_IER, r[15:8], "dlh");
        chk("divisor", divisor, r[15:0]);
        wr(ADDR_LCR, 8'h00);
        rd(ADDR_IER, 8'h00, "ier_back");
        // No earlier write carried clear bits; this one carries both
        chk("clr_none", 16'(clr_seen), 16'h0000);
        wr(ADDR_FCR, 8'h06);
        chk("clr_both", 16'(clr_seen), 16'h0003);
        chk("fcr_clr", 16'(fifo_control), 16'h0000);
        print_verdict;
    end

    // Run needs under 2000 cycles; cut a hang well beyond that
    initial begin
        #(25 * 20000);
        err_total++;
        print_verdict;
    end
endmodule

bind udr_ctrl udr_ctrl_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .stat_i(stat_i),
    .rdata_o(rdata_o), .tx_push_o(tx_push_o), .modem_control_o(modem_control_o),
    .enhanced_features_o(enhanced_features_o), .alternate_function_o(alternate_function_o),
    .line_control_o(line_control_o), .fifo_control_o(fifo_control_o),
    .tx_dma_request_o(tx_dma_request_o), .rx_dma_request_o(rx_dma_request_o),
    .uart_clk_en_o(uart_clk_en_o), .baud_clk_en_o(baud_clk_en_o), .asleep_o(asleep_o)
);
`default_nettype wire
